//--- rtl/iltl_consts.svh
// iltl_consts.svh: timing counts and thresholds for the isolated line transceiver logic
// assumes a 100 MHz clock; included by bare name, holds definitions only
`ifndef ILTL_CONSTS_SVH
`define ILTL_CONSTS_SVH

// clock period in picoseconds
`define ILTL_CLK_PS           10000
// edge pulse width in picoseconds, as printed (about 1 ns)
`define ILTL_PULSE_PS         1000
// refresh idle time in microseconds
`define ILTL_REFRESH_US       1
// watchdog silence time in microseconds
`define ILTL_WATCHDOG_US      5
// refresh period in cycles (least time, rounded up)
`define ILTL_REFRESH_CYC      ((`ILTL_REFRESH_US * 1000000 + `ILTL_CLK_PS - 1) / `ILTL_CLK_PS)
// watchdog timeout in cycles (longest time, rounded down)
`define ILTL_WATCHDOG_CYC     ((`ILTL_WATCHDOG_US * 1000000) / `ILTL_CLK_PS)
// thermal trip and release temperatures in degrees C
`define ILTL_TEMP_TRIP        8'h96
`define ILTL_TEMP_RELEASE     8'h8C
// receiver thresholds in millivolts (signed)
`define ILTL_RX_HIGH_MV       (-16'sd30)
`define ILTL_RX_LOW_MV        (-16'sd200)

`endif

//--- rtl/iltl_pkg.sv
// iltl_pkg.sv: types shared by the isolated line transceiver logic
// assumes nothing of its surroundings
package iltl_pkg;
   // receiver decision result
   typedef enum logic [1:0] {
      ILTL_RX_HIGH = 2'b00,
      ILTL_RX_LOW  = 2'b01,
      ILTL_RX_UNDEF = 2'b11
   } iltl_rx_t;
endpackage

//--- rtl/iltl_channel.sv
// iltl_channel.sv: one barrier channel, edge-pulse encoder, bistable decoder, refresh, watchdog
// assumes one clock; link_ok low models an unpowered sending side (pulses lost)
`include "iltl_consts.svh"
module iltl_channel
   import iltl_pkg::*;
#(
   parameter logic dflt_level = 1'b1   // level forced by the watchdog
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // sending side
   input  wire logic level_in,
   input  wire logic link_ok,
   // receiving side
   output logic      level_out,
   output logic      wd_fault
);
   localparam int unsigned PULSE_CYC = (`ILTL_PULSE_PS + `ILTL_CLK_PS - 1) / `ILTL_CLK_PS;
   localparam int unsigned REF_CYC   = `ILTL_REFRESH_CYC;
   localparam int unsigned WD_CYC    = `ILTL_WATCHDOG_CYC;
   initial begin
      if (PULSE_CYC < 1 || REF_CYC < 1 || WD_CYC <= REF_CYC)
         $error("iltl_channel: timing counts cannot be served");
   end

   logic        last_r;      // level last encoded
   logic [15:0] idle_r;      // cycles since last edge or refresh
   logic [15:0] wd_r;        // cycles since last received pulse
   logic        set_p;       // set pulse across barrier
   logic        rst_p;       // reset pulse across barrier
   logic        latch_r;     // bistable decoder
   logic        refresh;     // refresh due

   assign refresh = (idle_r >= 16'(REF_CYC - 1));

   // encoder: one-cycle pulse per edge, or a refresh after idle
   always_comb begin
      set_p = 1'b0;
      rst_p = 1'b0;
      if (link_ok && ((level_in != last_r) || refresh)) begin
         set_p = level_in;
         rst_p = ~level_in;
      end
   end

   // encoder state
   always_ff @(posedge clk) begin
      if (reset) begin
         last_r <= 1'b0;
         // refresh falls due at once, so every channel with link_ok high pulses on the first edge after release
         idle_r <= 16'(REF_CYC - 1);
      end else begin
         last_r <= level_in;
         if (set_p || rst_p) idle_r <= 16'h0000;
         else                idle_r <= idle_r + 16'h0001;
      end
   end

   // bistable decoder
   always_ff @(posedge clk) begin
      if (reset)      latch_r <= dflt_level;
      else if (set_p) latch_r <= 1'b1;
      else if (rst_p) latch_r <= 1'b0;
   end

   // watchdog on pulse silence
   always_ff @(posedge clk) begin
      if (reset)                wd_r <= 16'(WD_CYC);
      else if (set_p || rst_p)  wd_r <= 16'h0000;
      else if (wd_r < 16'(WD_CYC)) wd_r <= wd_r + 16'h0001;
   end

   assign wd_fault  = (wd_r >= 16'(WD_CYC));
   assign level_out = wd_fault ? dflt_level : latch_r;
endmodule // iltl_channel

//--- rtl/iltl_top.sv
// iltl_top.sv: digital model of an isolated differential multipoint transceiver
// assumes logic-side pins and bus-side sampled values synchronous to clk
`include "iltl_consts.svh"
module iltl_top
   import iltl_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // logic side
   input  wire logic        send_line_in,
   input  wire logic        drive_on,
   input  wire logic        listen_on_n,
   output logic             recv_line_out,
   output logic             recv_line_oe_n,
   // bus side driver, oe low while driving
   output logic             out_true_leg,
   output logic             out_comp_leg,
   output logic             out_leg_oe_n,
   // bus side receiver: sampled differential voltage and open-line flag
   input  wire logic signed [15:0] line_diff_mv,
   input  wire logic        line_open,
   // health inputs
   input  wire logic [7:0]  die_temp_c,
   input  wire logic        logic_side_ok,
   input  wire logic        bus_side_ok,
   // status
   output logic             thermal_off,
   output logic             link_fault
);
   logic     tx_bus;       // data on bus side
   logic     de_bus;       // enable on bus side
   logic     rx_logic;     // receive result on logic side
   logic     wd_tx;        // watchdog, data channel
   logic     wd_de;        // watchdog, enable channel
   logic     wd_rx;        // watchdog, receive channel
   logic     rx_dec;       // receiver decision on bus side
   logic     rx_held_r;    // last defined receiver level
   logic     hot_r;        // thermal shutdown state
   iltl_rx_t rx_cls;       // receiver classification

   // barrier channels logic to bus, bus to logic
   iltl_channel #(.dflt_level(1'b0)) u_ch_tx (
      .clk       (clk),
      .reset     (reset),
      .level_in  (send_line_in),
      .link_ok   (logic_side_ok),
      .level_out (tx_bus),
      .wd_fault  (wd_tx)
   );
   iltl_channel #(.dflt_level(1'b0)) u_ch_de (
      .clk       (clk),
      .reset     (reset),
      .level_in  (drive_on),
      .link_ok   (logic_side_ok),
      .level_out (de_bus),
      .wd_fault  (wd_de)
   );
   iltl_channel #(.dflt_level(1'b1)) u_ch_rx (
      .clk       (clk),
      .reset     (reset),
      .level_in  (rx_dec),
      .link_ok   (bus_side_ok),
      .level_out (rx_logic),
      .wd_fault  (wd_rx)
   );

   // receiver classification against thresholds
   always_comb begin
      if (line_open)                               rx_cls = ILTL_RX_HIGH;
      else if (line_diff_mv >= `ILTL_RX_HIGH_MV)   rx_cls = ILTL_RX_HIGH;
      else if (line_diff_mv <= `ILTL_RX_LOW_MV)    rx_cls = ILTL_RX_LOW;
      else                                         rx_cls = ILTL_RX_UNDEF;
   end

   // undefined band holds the last defined level
   always_ff @(posedge clk) begin
      if (reset) rx_held_r <= 1'b1;
      else begin
         case (rx_cls)
            ILTL_RX_HIGH: rx_held_r <= 1'b1;
            ILTL_RX_LOW:  rx_held_r <= 1'b0;
            default:      rx_held_r <= rx_held_r;
         endcase
      end
   end
   assign rx_dec = rx_held_r;

   // thermal shutdown with hysteresis
   always_ff @(posedge clk) begin
      if (reset)                                hot_r <= 1'b0;
      else if (die_temp_c >= `ILTL_TEMP_TRIP)   hot_r <= 1'b1;
      else if (die_temp_c <= `ILTL_TEMP_RELEASE) hot_r <= 1'b0;
   end

   // bus-side driver outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         out_true_leg <= 1'b0;
         out_comp_leg <= 1'b1;
         out_leg_oe_n <= 1'b1;
      end else begin
         out_true_leg <= tx_bus;
         out_comp_leg <= ~tx_bus;
         out_leg_oe_n <= ~(de_bus && !hot_r && !wd_tx && !wd_de);
      end
   end

   // logic-side receiver output
   always_ff @(posedge clk) begin
      if (reset) begin
         recv_line_out  <= 1'b1;
         recv_line_oe_n <= 1'b1;
      end else begin
         recv_line_out  <= wd_rx ? 1'b1 : rx_logic;
         recv_line_oe_n <= listen_on_n;
      end
   end

   // status flags
   always_ff @(posedge clk) begin
      if (reset) begin
         thermal_off <= 1'b0;
         link_fault  <= 1'b0;
      end else begin
         thermal_off <= hot_r;
         link_fault  <= wd_tx | wd_de | wd_rx;
      end
   end
endmodule // iltl_top

//--- verif/iltl_props.sv
// iltl_props.sv: port assertions for the isolated line transceiver logic
// assumes it is bound onto iltl_top, one clock, sync reset
module iltl_props (
   // clock, reset and logic side
   input wire logic               clk, reset, send_line_in, drive_on, listen_on_n,
   input wire logic               recv_line_out, recv_line_oe_n,
   // bus side
   input wire logic               out_true_leg, out_comp_leg, out_leg_oe_n, line_open,
   input wire logic signed [15:0] line_diff_mv,
   // health and status
   input wire logic [7:0]         die_temp_c,
   input wire logic               logic_side_ok, bus_side_ok, thermal_off, link_fault
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [9:0] dn_r;  // cycles with the logic side down
   logic [9:0] up_r;  // cycles with both sides up
   // saturating counters for the watchdog checks
   always_ff @(posedge clk) begin
      dn_r <= (reset || logic_side_ok) ? 10'h000 : dn_r + 10'(dn_r != 10'h3ff);
      up_r <= (reset || !logic_side_ok || !bus_side_ok) ? 10'h000 : up_r + 10'(up_r != 10'h3ff);
   end
   a_legs_compl: assert property (!out_leg_oe_n |-> out_comp_leg != out_true_leg)
      else $error("legs not complementary");
   a_drive_follow: assert property ((drive_on && $stable(send_line_in) && !thermal_off && !link_fault)[*6]
      |-> !out_leg_oe_n && out_true_leg == send_line_in) else $error("driver not following data");
   a_drive_off: assert property ((!drive_on)[*5] |-> out_leg_oe_n)
      else $error("driver on while disabled");
   a_rx_enable: assert property (1 |=> recv_line_oe_n == $past(listen_on_n))
      else $error("receiver enable wrong");
   a_rx_high: assert property ((line_open || line_diff_mv >= -16'sd30)[*6] |-> recv_line_oe_n || recv_line_out)
      else $error("receiver not high");
   a_rx_low: assert property ((!line_open && line_diff_mv <= -16'sd200 && bus_side_ok && !link_fault)[*8]
      |-> recv_line_oe_n || !recv_line_out) else $error("receiver not low");
   a_temp_trip: assert property (die_temp_c >= 8'h96 |-> ##[1:3] thermal_off)
      else $error("no thermal trip");
   a_temp_hold: assert property ((thermal_off && die_temp_c > 8'h8c)[*3] |=> thermal_off)
      else $error("thermal released early");
   a_temp_free: assert property ((die_temp_c <= 8'h8c)[*3] |-> !thermal_off)
      else $error("thermal not released");
   a_therm_legs: assert property (thermal_off [*3] |-> out_leg_oe_n)
      else $error("legs on in shutdown");
   a_refresh_ok: assert property (up_r > 10'd8 |-> !link_fault)
      else $error("fault while powered");
   a_wd_default: assert property (dn_r > 10'd520 |-> link_fault && out_leg_oe_n)
      else $error("watchdog default missing");
endmodule // iltl_props

bind iltl_top iltl_props i_props (.*);

//--- verif/iltl_bus_model.sv
// iltl_bus_model.sv: bus wire with one far driver and a terminator
// assumes millivolt levels; driver legs come from the design
module iltl_bus_model (
   input wire logic               out_true_leg, out_leg_oe_n, far_on, far_open,
   input wire logic signed [15:0] far_mv,
   output logic signed [15:0]     line_diff_mv,
   output logic                   line_open
);
   // own driver wins, then far driver, else terminator decays to 0 V
   always_comb begin
      if (!out_leg_oe_n) line_diff_mv = out_true_leg ? 16'sh07d0 : -16'sh07d0;
      else if (far_on) line_diff_mv = far_mv;
      else line_diff_mv = 16'sh0000;
      line_open = far_open && out_leg_oe_n;
   end
endmodule // iltl_bus_model

//--- verif/tb_top.sv
// tb_top.sv: self-checking bench for iltl_top
// assumes 100 MHz clock; inputs change at the falling edge
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset = 1, send_line_in = 0, drive_on = 0, listen_on_n = 0;
   logic far_on = 0, far_open = 0, logic_side_ok = 1, bus_side_ok = 1, line_open;
   logic signed [15:0] far_mv = 16'sh0000, line_diff_mv;
   logic [7:0] die_temp_c = 8'h19;
   logic recv_line_out, recv_line_oe_n, out_true_leg, out_comp_leg, out_leg_oe_n, thermal_off, link_fault;
   int failures = 0, num_checks = 0;
   always #5 clk = ~clk;
   iltl_top i_dut (.*);
   iltl_bus_model i_bus (.*);
   // compare and report
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task w(input int n);
      repeat (n) @(negedge clk);
   endtask
   task complete_run;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // driver levels, loopback through the bus, release
   task t_tx;
      drive_on = 1;
      for (int i = 0; i < 4; i++) begin
         send_line_in = i[0];
         w(8);
         chk(out_leg_oe_n, 0); chk(out_true_leg, i[0]); chk(out_comp_leg, !i[0]);
         chk(recv_line_out, i[0]);
      end
      drive_on = 0; w(6); chk(out_leg_oe_n, 1);
      $display("tx test done");
   endtask
   // receiver thresholds, undefined band, fail-safe, enable
   task t_rx;
      logic [15:0] mv [7] = '{16'h0000, 16'hffe2, 16'hff38, 16'hff9c, 16'h01f4, 16'hff9c, 16'hfc18};
      logic        ex [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      far_on = 1;
      for (int i = 0; i < 7; i++) begin
         far_mv = mv[i]; w(8); chk(recv_line_out, ex[i]);
      end
      far_on = 0; w(8); chk(recv_line_out, 1);
      far_on = 1; w(8); chk(recv_line_out, 0);
      far_open = 1; w(8); chk(recv_line_out, 1);
      far_open = 0; listen_on_n = 1; w(2); chk(recv_line_oe_n, 1);
      listen_on_n = 0; w(2); chk(recv_line_oe_n, 0);
      $display("rx test done");
   endtask
   // thermal trip and hysteresis
   task t_therm;
      logic [7:0] tc [4] = '{8'h95, 8'h96, 8'h8d, 8'h8c};
      logic       ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      drive_on = 1; send_line_in = 1;
      for (int i = 0; i < 4; i++) begin
         die_temp_c = tc[i]; w(6); chk(thermal_off, ex[i]); chk(out_leg_oe_n, ex[i]);
      end
      $display("thermal test done");
   endtask
   // refresh at steady state, watchdog on each side
   task t_wd;
      w(700); chk(link_fault, 0); chk(out_leg_oe_n, 0);
      logic_side_ok = 0; w(540); chk(link_fault, 1); chk(out_leg_oe_n, 1);
      logic_side_ok = 1; w(10); chk(link_fault, 0); chk(out_leg_oe_n, 0);
      drive_on = 0; far_mv = 16'hfc18; w(10); chk(recv_line_out, 0);
      bus_side_ok = 0; w(540); chk(recv_line_out, 1); chk(link_fault, 1);
      bus_side_ok = 1; w(10); chk(recv_line_out, 0);
      $display("watchdog test done");
   endtask
   initial begin
      w(10);
      chk(out_leg_oe_n, 1); chk(recv_line_out, 1); chk(recv_line_oe_n, 1);
      reset = 0;
      w(5);
      t_tx;
      t_rx;
      t_therm;
      t_wd;
      complete_run;
   end
   // hang guard, about ten times the expected run
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run;
   end
endmodule // tb_top
